// ---- src/sysctl_pkg.sv ----
package sysctl_pkg;

	// ************************************************************
	// Address map
	// ************************************************************
	typedef logic [17:0] addr_t;
	localparam addr_t IO_BASE           = 18'h0_3f00;
	localparam addr_t ROM_BASE          = 18'h0_4000;
	localparam addr_t CPU_MODE_ADDR     = 18'h0_3f00;
	localparam addr_t MEM_BUS_CTRL_ADDR = 18'h0_3f01;
	localparam addr_t LS_SEL_ADDR       = 18'h0_3f4c;

	// ************************************************************
	// Register fields and reset values
	// ************************************************************
	localparam logic [7:0] MEM_BUS_CTRL_RST = 8'hcb;
	localparam int         IO_WAIT_MSB      = 7;
	localparam int         IO_WAIT_LSB      = 6;
	localparam int         VEC_BASE_BIT     = 5;
	localparam int         REQ_WE_BIT       = 2;
	localparam addr_t      VEC_BASE_CLR     = 18'h0_4000;
	localparam addr_t      VEC_BASE_SET     = 18'h0_0100;
	localparam logic       LS_SEL_RST       = 1'b0;
	localparam int         LS_SEL_BIT       = 0;
	localparam logic [3:0] CPU_MODE_HI_RST  = 4'h0;
	localparam int         CLK_DIV_MSB      = 6;
	localparam int         CLK_DIV_LSB      = 4;

	// Mode request codes in the low nibble of cpu_mode_control.
	localparam logic [3:0] MODE_CODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_CODE_IDLE   = 4'h1;
	localparam logic [3:0] MODE_CODE_SLOW   = 4'h3;
	localparam logic [3:0] MODE_CODE_HALT   = 4'h4;
	localparam logic [3:0] MODE_CODE_STOP   = 4'h8;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int                    STAB_CNT_W    = 15;
	localparam logic [STAB_CNT_W-1:0] STAB_WAIT_DEF = 15'h4000;
	typedef logic [1:0] wait_cnt_t;
	localparam wait_cnt_t NO_WAIT = 2'h0;

	// ************************************************************
	// Types and helpers
	// ************************************************************
	typedef enum logic [1:0] {TGT_RAM = 2'b00, TGT_IO = 2'b01, TGT_ROM = 2'b10} target_t;

	typedef enum logic [3:0] {
		ST_NORMAL    = 4'b0000,
		ST_IDLE      = 4'b0001,
		ST_SLOW      = 4'b0010,
		ST_HALT_NORM = 4'b0011,
		ST_HALT_SLOW = 4'b0100,
		ST_STOP_NORM = 4'b0101,
		ST_STOP_SLOW = 4'b0110,
		ST_WAIT_NORM = 4'b0111,
		ST_WAIT_SLOW = 4'b1000
	} mode_t;

	// Which of the three buses an address belongs to.
	function automatic target_t decode_target(input addr_t a);
		if (a >= ROM_BASE)
			return TGT_ROM;
		else if (a >= IO_BASE)
			return TGT_IO;
		return TGT_RAM;
	endfunction

	// True for the registers held inside this block.
	function automatic logic is_own_reg(input addr_t a);
		return (a == CPU_MODE_ADDR) || (a == MEM_BUS_CTRL_ADDR) || (a == LS_SEL_ADDR);
	endfunction

endpackage

// ---- src/io_wait_timer.sv ----
`timescale 1ns/100ps
module io_wait_timer (
	// Clock and reset.
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	// Load and status.
	input  wire logic                  start_in,
	input  wire sysctl_pkg::wait_cnt_t count_in,
	output logic                       busy_out
);
	import sysctl_pkg::*;

	wait_cnt_t cnt_r;

	// Loads the wait count and runs it down to zero, one per clock.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			cnt_r <= NO_WAIT;
		else if (start_in)
			cnt_r <= count_in;
		else if (cnt_r != NO_WAIT)
			cnt_r <= cnt_r - 2'h1;
	end

	// Busy while wait cycles remain.
	assign busy_out = (cnt_r != NO_WAIT);

endmodule // io_wait_timer

// ---- src/bus_wait_and_standby_control.sv ----
`timescale 1ns/100ps
module bus_wait_and_standby_control #(
	parameter logic [sysctl_pkg::STAB_CNT_W-1:0] STAB_WAIT_CYCLES = sysctl_pkg::STAB_WAIT_DEF
) (
	// Clock and reset.
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	// Instruction fetch port.
	input  wire logic              fetch_req_in,
	input  wire sysctl_pkg::addr_t fetch_addr_in,
	output logic                   fetch_ack_out,
	output logic [7:0]             fetch_rdata_out,
	// Data access port.
	input  wire logic              data_req_in,
	input  wire logic              data_we_in,
	input  wire sysctl_pkg::addr_t data_addr_in,
	input  wire logic [7:0]        data_wdata_in,
	output logic                   data_ack_out,
	output logic [7:0]             data_rdata_out,
	// ROM bus.
	output sysctl_pkg::addr_t      rom_addr_out,
	output logic                   rom_rd_out,
	input  wire logic [7:0]        rom_rdata_in,
	// RAM bus.
	output sysctl_pkg::addr_t      ram_addr_out,
	output logic                   ram_rd_out,
	output logic                   ram_we_out,
	output logic [7:0]             ram_wdata_out,
	input  wire logic [7:0]        ram_rdata_in,
	// Peripheral bus.
	output logic [7:0]             io_addr_out,
	output logic                   io_rd_out,
	output logic                   io_we_out,
	output logic [7:0]             io_wdata_out,
	input  wire logic [7:0]        io_rdata_in,
	// Standby and clock control.
	input  wire logic              wake_irq_in,
	output logic                   high_freq_oscillator_en_out,
	output logic                   low_freq_oscillator_en_out,
	output logic                   low_clk_sel_out,
	output logic                   cpu_run_out,
	output logic                   stab_wait_out,
	output logic [2:0]             clk_div_sel_out,
	// Interrupt and pin control.
	output logic                   irq_flag_write_en_out,
	output sysctl_pkg::addr_t      vector_base_out,
	output logic                   shared_osc_pin_xtal_out
);
	import sysctl_pkg::*;

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [7:0]            memory_bus_control_r;
	logic                  low_speed_osc_select_r;
	logic [3:0]            cpu_mode_hi_r;
	mode_t                 mode_r;
	logic [STAB_CNT_W-1:0] stab_cnt_r;
	logic                  fetch_act_r;
	logic                  fetch_ack_r;
	addr_t                 fetch_addr_r;
	logic [7:0]            fetch_rdata_r;
	logic                  data_act_r;
	logic                  data_ack_r;
	target_t               data_tgt_r;
	logic                  data_own_r;
	logic                  data_we_r;
	addr_t                 data_addr_r;
	logic [7:0]            data_wdata_r;
	logic [7:0]            data_rdata_r;
	target_t               take_tgt;
	wait_cnt_t             take_wait;
	logic                  rom_busy;
	logic                  fetch_take;
	logic                  data_take;
	logic                  tmr_busy;
	logic                  data_fin;
	logic                  own_wr;
	logic                  mode_wr;
	logic [3:0]            mode_req;
	logic [3:0]            mode_code;
	logic [7:0]            own_rdata;
	logic [7:0]            bus_rdata;

	// ************************************************************
	// Bus arbitration
	// ************************************************************
	// The ROM bus is the only shared one; fetch wins a same-cycle tie so
	// the pipeline keeps moving, and a data read of ROM simply waits.
	// parallel bus access
	assign take_tgt   = decode_target(data_addr_in);
	assign rom_busy   = fetch_act_r || (data_act_r && data_tgt_r == TGT_ROM);
	assign fetch_take = fetch_req_in && !fetch_act_r && !fetch_ack_r && !rom_busy;
	assign data_take  = data_req_in && !data_act_r && !data_ack_r
		&& !(take_tgt == TGT_ROM && (rom_busy || fetch_take));
	assign take_wait  = (take_tgt == TGT_IO) ?
		wait_cnt_t'(memory_bus_control_r[IO_WAIT_MSB:IO_WAIT_LSB]) : NO_WAIT;
	assign data_fin   = data_act_r && !tmr_busy;

	io_wait_timer u_wait (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.start_in (data_take),
		.count_in (take_wait),
		.busy_out (tmr_busy)
	);

	// Fetch: address out for one cycle, data captured and acknowledged at the same edge.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			fetch_act_r   <= 1'b0;
			fetch_ack_r   <= 1'b0;
			fetch_addr_r  <= '0;
			fetch_rdata_r <= 8'h00;
		end
		else
		begin
			fetch_ack_r <= fetch_act_r;
			if (fetch_take)
			begin
				fetch_act_r  <= 1'b1;
				fetch_addr_r <= fetch_addr_in;
			end
			else if (fetch_act_r)
			begin
				fetch_act_r   <= 1'b0;
				fetch_rdata_r <= rom_rdata_in;
			end
		end
	end

	// Data access: latched at take, held through the wait cycles.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			data_act_r   <= 1'b0;
			data_ack_r   <= 1'b0;
			data_tgt_r   <= TGT_RAM;
			data_own_r   <= 1'b0;
			data_we_r    <= 1'b0;
			data_addr_r  <= '0;
			data_wdata_r <= 8'h00;
			data_rdata_r <= 8'h00;
		end
		else
		begin
			data_ack_r <= data_fin;
			if (data_take)
			begin
				data_act_r   <= 1'b1;
				data_tgt_r   <= take_tgt;
				data_own_r   <= is_own_reg(data_addr_in);
				data_we_r    <= data_we_in;
				data_addr_r  <= data_addr_in;
				data_wdata_r <= data_wdata_in;
			end
			else if (data_fin)
			begin
				data_act_r <= 1'b0;
				if (!data_we_r)
					data_rdata_r <= data_own_r ? own_rdata : bus_rdata;
			end
		end
	end

	// Read data source by target bus.
	always_comb
	begin
		case (data_tgt_r)
			TGT_ROM: bus_rdata = rom_rdata_in;
			TGT_IO:  bus_rdata = io_rdata_in;
			default: bus_rdata = ram_rdata_in;
		endcase
	end

	// Bus strobes follow the latched request; ROM ignores writes.
	assign rom_addr_out    = fetch_act_r ? fetch_addr_r : data_addr_r;
	assign rom_rd_out      = fetch_act_r || (data_act_r && data_tgt_r == TGT_ROM && !data_we_r);
	assign ram_addr_out    = data_addr_r;
	assign ram_rd_out      = data_act_r && data_tgt_r == TGT_RAM && !data_we_r;
	assign ram_we_out      = data_act_r && data_tgt_r == TGT_RAM && data_we_r;
	assign ram_wdata_out   = data_wdata_r;
	assign io_addr_out     = data_addr_r[7:0];
	assign io_rd_out       = data_act_r && data_tgt_r == TGT_IO && !data_own_r && !data_we_r;
	assign io_we_out       = data_act_r && data_tgt_r == TGT_IO && !data_own_r && data_we_r;
	assign io_wdata_out    = data_wdata_r;
	assign fetch_ack_out   = fetch_ack_r;
	assign fetch_rdata_out = fetch_rdata_r;
	assign data_ack_out    = data_ack_r;
	assign data_rdata_out  = data_rdata_r;

	// ************************************************************
	// Registers
	// ************************************************************
	// Writes land at the end of the access, after any wait cycles.
	assign own_wr   = data_fin && data_we_r && data_own_r;
	assign mode_wr  = own_wr && data_addr_r == CPU_MODE_ADDR;
	assign mode_req = data_wdata_r[3:0];

	// Register file; reserved bits of the bus control register store as written.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			memory_bus_control_r   <= MEM_BUS_CTRL_RST;
			low_speed_osc_select_r <= LS_SEL_RST;
			cpu_mode_hi_r          <= CPU_MODE_HI_RST;
		end
		else if (own_wr)
		begin
			if (data_addr_r == MEM_BUS_CTRL_ADDR)
				memory_bus_control_r <= data_wdata_r;
			if (data_addr_r == LS_SEL_ADDR)
				low_speed_osc_select_r <= data_wdata_r[LS_SEL_BIT];
			if (data_addr_r == CPU_MODE_ADDR)
				cpu_mode_hi_r <= data_wdata_r[7:4];
		end
	end

	// Mode field reads back the mode the CPU is running in.
	always_comb
	begin
		case (mode_r)
			ST_IDLE: mode_code = MODE_CODE_IDLE;
			ST_SLOW: mode_code = MODE_CODE_SLOW;
			default: mode_code = MODE_CODE_NORMAL;
		endcase
	end

	// Own register read mux; upper bits of the pin select read as zero.
	always_comb
	begin
		case (data_addr_r)
			CPU_MODE_ADDR:     own_rdata = {cpu_mode_hi_r, mode_code};
			MEM_BUS_CTRL_ADDR: own_rdata = memory_bus_control_r;
			LS_SEL_ADDR:       own_rdata = {7'h00, low_speed_osc_select_r};
			default:           own_rdata = 8'h00;
		endcase
	end

	assign vector_base_out = memory_bus_control_r[VEC_BASE_BIT] ? VEC_BASE_SET : VEC_BASE_CLR;
	assign irq_flag_write_en_out = memory_bus_control_r[REQ_WE_BIT];
	assign shared_osc_pin_xtal_out = low_speed_osc_select_r;
	// Divider select is the stored upper field of the mode register, whatever the wait field.
	assign clk_div_sel_out = cpu_mode_hi_r[CLK_DIV_MSB-4:CLK_DIV_LSB-4];

	// ************************************************************
	// Mode controller
	// ************************************************************
	// Reset enters the stabilisation wait, so the CPU never runs on an
	// unsettled fast clock. The wait counts this block's clock, which is
	// assumed to keep running while the oscillators are stopped.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			mode_r     <= ST_WAIT_NORM;
			stab_cnt_r <= STAB_WAIT_CYCLES;
		end
		else
		begin
			case (mode_r)
				ST_NORMAL:
					if (mode_wr)
					begin
						case (mode_req)
							MODE_CODE_SLOW: mode_r <= ST_SLOW;
							MODE_CODE_HALT: mode_r <= ST_HALT_NORM;
							MODE_CODE_STOP: mode_r <= ST_STOP_NORM;
							default:        mode_r <= ST_NORMAL;
						endcase
					end
				ST_SLOW:
					if (mode_wr)
					begin
						case (mode_req)
							MODE_CODE_IDLE: mode_r <= ST_IDLE;
							MODE_CODE_HALT: mode_r <= ST_HALT_SLOW;
							MODE_CODE_STOP: mode_r <= ST_STOP_SLOW;
							default:        mode_r <= ST_SLOW;
						endcase
					end
				ST_IDLE:
					if (mode_wr && mode_req == MODE_CODE_NORMAL)
						mode_r <= ST_NORMAL;
				ST_HALT_NORM:
					if (wake_irq_in)
						mode_r <= ST_NORMAL;
				ST_HALT_SLOW:
					if (wake_irq_in)
						mode_r <= ST_SLOW;
				ST_STOP_NORM:
					if (wake_irq_in)
					begin
						mode_r     <= ST_WAIT_NORM;
						stab_cnt_r <= STAB_WAIT_CYCLES;
					end
				ST_STOP_SLOW:
					if (wake_irq_in)
					begin
						mode_r     <= ST_WAIT_SLOW;
						stab_cnt_r <= STAB_WAIT_CYCLES;
					end
				ST_WAIT_NORM, ST_WAIT_SLOW:
					if (stab_cnt_r == '0)
						mode_r <= (mode_r == ST_WAIT_SLOW) ? ST_SLOW : ST_NORMAL;
					else
						stab_cnt_r <= stab_cnt_r - 15'h0001;
				default:
					mode_r <= ST_NORMAL;
			endcase
		end
	end

	// Oscillator and CPU clock gating decoded from the mode register and, for the slow oscillator, the low-speed select.
	// halt oscillator states
	assign high_freq_oscillator_en_out = (mode_r == ST_NORMAL) || (mode_r == ST_IDLE)
		|| (mode_r == ST_HALT_NORM) || (mode_r == ST_WAIT_NORM);
	assign low_clk_sel_out = (mode_r == ST_IDLE) || (mode_r == ST_SLOW)
		|| (mode_r == ST_HALT_SLOW) || (mode_r == ST_WAIT_SLOW);
	assign low_freq_oscillator_en_out = low_clk_sel_out || (low_speed_osc_select_r
		&& ((mode_r == ST_NORMAL) || (mode_r == ST_HALT_NORM) || (mode_r == ST_WAIT_NORM)));
	assign cpu_run_out   = (mode_r == ST_NORMAL) || (mode_r == ST_IDLE) || (mode_r == ST_SLOW);
	assign stab_wait_out = (mode_r == ST_WAIT_NORM) || (mode_r == ST_WAIT_SLOW);

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_io_wait3;
		(data_take && take_tgt == TGT_IO && memory_bus_control_r[7:6] == 2'h3)
			|=> !data_ack_out [*4] ##1 data_ack_out;
	endproperty
	a_io_wait3: assert property (p_io_wait3) else $error("three-wait access timing wrong");

	property p_io_wait0;
		(data_take && take_tgt == TGT_IO && memory_bus_control_r[7:6] == 2'h0)
			|=> !data_ack_out ##1 data_ack_out;
	endproperty
	a_io_wait0: assert property (p_io_wait0) else $error("no-wait access timing wrong");

	property p_reset_wait;
		$past(rst_in) |-> memory_bus_control_r[7:6] == 2'h3;
	endproperty
	a_reset_wait: assert property (p_reset_wait) else $error("wait field not three after reset");

	property p_vec_base;
		$rose(memory_bus_control_r[VEC_BASE_BIT]) |-> vector_base_out == VEC_BASE_SET;
	endproperty
	a_vec_base: assert property (p_vec_base) else $error("vector base not switched");

	property p_req_we;
		(own_wr && data_addr_r == MEM_BUS_CTRL_ADDR && !data_wdata_r[2]) |=> !irq_flag_write_en_out;
	endproperty
	a_req_we: assert property (p_req_we) else $error("request write enable stuck");

	property p_parallel;
		(fetch_take && data_take && take_tgt == TGT_RAM) |=> fetch_act_r && (ram_rd_out || ram_we_out);
	endproperty
	a_parallel: assert property (p_parallel) else $error("fetch and RAM access not parallel");

	property p_halt_slow;
		mode_r == ST_HALT_SLOW |-> !high_freq_oscillator_en_out && low_freq_oscillator_en_out;
	endproperty
	a_halt_slow: assert property (p_halt_slow) else $error("slow halt oscillators wrong");

	property p_halt_wake;
		(mode_r == ST_HALT_NORM && wake_irq_in) |=> cpu_run_out && !low_clk_sel_out;
	endproperty
	a_halt_wake: assert property (p_halt_wake) else $error("halt exit not immediate");

	property p_stop_off;
		(mode_r == ST_STOP_NORM || mode_r == ST_STOP_SLOW) |-> !cpu_run_out
			&& !high_freq_oscillator_en_out && !low_freq_oscillator_en_out;
	endproperty
	a_stop_off: assert property (p_stop_off) else $error("stop left something running");

	property p_stop_wake;
		(mode_r == ST_STOP_SLOW && wake_irq_in) |=> (stab_wait_out && !cpu_run_out) [*2];
	endproperty
	a_stop_wake: assert property (p_stop_wake) else $error("stop exit skipped wait");

	property p_slow_refuse;
		(mode_r == ST_SLOW && mode_wr && mode_req == MODE_CODE_NORMAL) |=> mode_r == ST_SLOW;
	endproperty
	a_slow_refuse: assert property (p_slow_refuse) else $error("slow to normal accepted");

	c_idle_path: cover property (mode_r == ST_IDLE ##[1:1000] mode_r == ST_NORMAL);
	c_stop_slow: cover property (mode_r == ST_WAIT_SLOW ##1 mode_r == ST_SLOW);
	c_io_access: cover property (data_take && take_tgt == TGT_IO ##[1:6] data_ack_out);
	c_both_buses: cover property (fetch_take && data_take);

endmodule // bus_wait_and_standby_control

// ---- testbench/mem_partner.sv ----
`timescale 1ns/100ps
// ********
// Memory side model
// ********
// Answers the ROM, RAM and peripheral buses.
module mem_partner (
	// Clock.
	input  wire logic              clk_in,
	// ROM bus.
	input  wire sysctl_pkg::addr_t rom_addr_in,
	input  wire logic              rom_rd_in,
	output logic [7:0]             rom_rdata_out,
	// RAM bus.
	input  wire sysctl_pkg::addr_t ram_addr_in,
	input  wire logic              ram_rd_in,
	input  wire logic              ram_we_in,
	input  wire logic [7:0]        ram_wdata_in,
	output logic [7:0]             ram_rdata_out,
	// Peripheral bus.
	input  wire logic [7:0]        io_addr_in,
	input  wire logic              io_rd_in,
	input  wire logic              io_we_in,
	input  wire logic [7:0]        io_wdata_in,
	output logic [7:0]             io_rdata_out
);
	import sysctl_pkg::*;
	logic [7:0] ram_mem [0:16383];
	logic [7:0] io_mem  [0:255];
	logic [7:0] rom_val;

	// Writes land at the edge that ends the strobe cycle.
	always_ff @(posedge clk_in)
	begin
		if (ram_we_in)
			ram_mem[ram_addr_in[13:0]] <= ram_wdata_in;
		if (io_we_in)
			io_mem[io_addr_in] <= io_wdata_in;
	end

	// Unstrobed buses show inverted data, so a stale sample cannot pass.
	assign rom_val       = rom_addr_in[7:0] ^ 8'h5a;
	assign rom_rdata_out = rom_rd_in ? rom_val : ~rom_val;
	assign ram_rdata_out = ram_rd_in ? ram_mem[ram_addr_in[13:0]] : ~ram_mem[ram_addr_in[13:0]];
	assign io_rdata_out  = io_rd_in ? io_mem[io_addr_in] : ~io_mem[io_addr_in];
endmodule // mem_partner

// ---- testbench/bus_wait_and_standby_control_bench.sv ----
`timescale 1ns/100ps
module bus_wait_and_standby_control_bench;
	import sysctl_pkg::*;
	localparam int STAB = 8;
	logic clk_in = 1'b0, rst_in = 1'b1, wake_irq_in = 1'b0;
	logic fetch_req_in = 1'b0, data_req_in = 1'b0, data_we_in = 1'b0;
	addr_t fetch_addr_in = '0, data_addr_in = '0;
	logic [7:0] data_wdata_in = 8'h00;
	logic fetch_ack_out, data_ack_out, rom_rd_out, ram_rd_out, ram_we_out, io_rd_out, io_we_out;
	logic [7:0] fetch_rdata_out, data_rdata_out, rom_rdata_in, ram_wdata_out, ram_rdata_in;
	logic [7:0] io_addr_out, io_wdata_out, io_rdata_in;
	addr_t rom_addr_out, ram_addr_out, vector_base_out;
	logic high_freq_oscillator_en_out, low_freq_oscillator_en_out, low_clk_sel_out;
	logic cpu_run_out, stab_wait_out, irq_flag_write_en_out, shared_osc_pin_xtal_out;
	logic [2:0] clk_div_sel_out;
	int miscompares = 0, samples_checked = 0;

	bus_wait_and_standby_control #(.STAB_WAIT_CYCLES(15'(STAB))) bus_wait_and_standby_control_i (.*);
	mem_partner mem_partner_i (.clk_in(clk_in), .rom_addr_in(rom_addr_out),
		.rom_rd_in(rom_rd_out), .rom_rdata_out(rom_rdata_in), .ram_addr_in(ram_addr_out),
		.ram_rd_in(ram_rd_out), .ram_we_in(ram_we_out), .ram_wdata_in(ram_wdata_out),
		.ram_rdata_out(ram_rdata_in), .io_addr_in(io_addr_out), .io_rd_in(io_rd_out),
		.io_we_in(io_we_out), .io_wdata_in(io_wdata_out), .io_rdata_out(io_rdata_in));

	// Free running 100 MHz clock; the slow rate is only a select level here.
	// fast clock ratio
	always #5 clk_in = ~clk_in;

	// ********
	// Checking helpers
	// ********
	task automatic check_val(input logic [17:0] got, input logic [17:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_lat(input int got, input int exp);
		samples_checked++;
		if (got != exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t count %0d expected %0d", $time, got, exp);
		end
	endtask

	// Oscillator and run state packed as fast, slow, run.
	task automatic state_is(input logic [2:0] exp);
		check_val({high_freq_oscillator_en_out, low_freq_oscillator_en_out, cpu_run_out}, exp);
	endtask

	function automatic logic [7:0] rom_byte(input addr_t a);
		return a[7:0] ^ 8'h5a;
	endfunction

	task automatic report_and_stop();
		if (miscompares == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ********
	// Bus drivers
	// ********
	// Request held from a falling edge until the acknowledge edge, released after it.
	task automatic access(input logic we, input addr_t a, input logic [7:0] wd,
		output logic [7:0] rd, output int n);
		n = 0;
		@(negedge clk_in);
		data_we_in = we;
		data_addr_in = a;
		data_wdata_in = wd;
		data_req_in = 1'b1;
		do
		begin
			@(posedge clk_in);
			#1 n++;
		end
		while (data_ack_out !== 1'b1 && n < 50);
		check_val(data_ack_out, 1'b1);
		rd = data_rdata_out;
		@(posedge clk_in);
		@(negedge clk_in);
		data_req_in = 1'b0;
	endtask

	task automatic fetch(input addr_t a, output logic [7:0] rd, output int n);
		n = 0;
		@(negedge clk_in);
		fetch_addr_in = a;
		fetch_req_in = 1'b1;
		do
		begin
			@(posedge clk_in);
			#1 n++;
		end
		while (fetch_ack_out !== 1'b1 && n < 50);
		check_val(fetch_ack_out, 1'b1);
		rd = fetch_rdata_out;
		@(posedge clk_in);
		@(negedge clk_in);
		fetch_req_in = 1'b0;
	endtask

	// Counts edges until the CPU runs; the wake request is held meanwhile.
	task automatic wait_run(input logic wake, output int n);
		n = 0;
		wake_irq_in = wake;
		do
		begin
			@(posedge clk_in);
			#1 n++;
		end
		while (cpu_run_out !== 1'b1 && n < 60);
		check_val(cpu_run_out, 1'b1);
		@(negedge clk_in);
		wake_irq_in = 1'b0;
	endtask

	// ********
	// Main sequence
	// ********
	initial
	begin
		logic [7:0] rd, d, fd;
		addr_t a, fa;
		int n, fn;
		logic [3:0] codes [8];
		logic [2:0] exp [8];
		int wk [8];
		codes = '{4'h3, 4'h0, 4'h4, 4'h8, 4'h1, 4'h0, 4'h4, 4'h8};
		exp = '{3'b011, 3'b011, 3'b010, 3'b000, 3'b111, 3'b111, 3'b110, 3'b000};
		wk = '{0, 0, 1, 2, 0, 0, 1, 2};
		void'($urandom(39868));
		repeat (12) @(posedge clk_in);
		@(negedge clk_in);
		rst_in = 1'b0;
		check_val({stab_wait_out, high_freq_oscillator_en_out, cpu_run_out}, 3'b110);
		check_val(vector_base_out, VEC_BASE_CLR);
		check_val(irq_flag_write_en_out, 1'b0);
		check_val(shared_osc_pin_xtal_out, 1'b0);
		wait_run(1'b0, n);
		check_lat(n, STAB + 1);
		access(1'b0, MEM_BUS_CTRL_ADDR, 8'h00, rd, n);
		check_val(rd, MEM_BUS_CTRL_RST);
		check_lat(n, 5);
		for (int w = 3; w >= 0; w--)
		begin
			access(1'b1, MEM_BUS_CTRL_ADDR, {w[1:0], 6'h0b}, rd, n);
			d = 8'($urandom);
			access(1'b1, addr_t'(18'h0_3f10 + w), d, rd, n);
			access(1'b0, addr_t'(18'h0_3f10 + w), 8'h00, rd, n);
			check_val(rd, d);
			check_lat(n, 2 + w);
		end
		access(1'b1, MEM_BUS_CTRL_ADDR, 8'h2f, rd, n);
		access(1'b0, MEM_BUS_CTRL_ADDR, 8'h00, rd, n);
		check_val(rd, 8'h2f);
		check_val(vector_base_out, VEC_BASE_SET);
		check_val(irq_flag_write_en_out, 1'b1);
		access(1'b1, LS_SEL_ADDR, 8'hff, rd, n);
		access(1'b0, LS_SEL_ADDR, 8'h00, rd, n);
		check_val(rd, 8'h01);
		check_val(shared_osc_pin_xtal_out, 1'b1);
		repeat (6)
		begin
			a = addr_t'($urandom_range(32'h3eff));
			d = 8'($urandom);
			fa = ROM_BASE + addr_t'($urandom_range(32'hffff));
			access(1'b1, a, d, rd, n);
			fork
				fetch(fa, fd, fn);
				access(1'b0, a, 8'h00, rd, n);
			join
			check_val(rd, d);
			check_val(fd, rom_byte(fa));
			check_lat(fn + n, 4);
			access(1'b0, fa, 8'h00, rd, n);
			check_val(rd, rom_byte(fa));
		end
		for (int i = 0; i < 8; i++)
		begin
			access(1'b1, CPU_MODE_ADDR, {4'h0, codes[i]}, rd, n);
			state_is(exp[i]);
			if (wk[i] == 0)
				check_val(low_clk_sel_out, 1'(i < 5));
			else
			begin
				repeat (3) fetch(ROM_BASE, fd, fn);
				check_val(fd, rom_byte(ROM_BASE));
				wait_run(1'b1, n);
				check_lat(n, wk[i] == 1 ? 1 : STAB + 2);
				state_is(i < 4 ? 3'b011 : 3'b111);
			end
		end
		// Divider field is stored and the running mode reads back in the low nibble.
		access(1'b1, CPU_MODE_ADDR, 8'h50, rd, n);
		state_is(3'b111);
		access(1'b0, CPU_MODE_ADDR, 8'h00, rd, n);
		check_val(rd, {4'h5, MODE_CODE_NORMAL});
		check_val(clk_div_sel_out, 3'h5);
		// A reset in the middle of stop ends standby and restarts the wait.
		access(1'b1, CPU_MODE_ADDR, 8'h58, rd, n);
		state_is(3'b000);
		@(negedge clk_in);
		rst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		rst_in = 1'b0;
		check_val({stab_wait_out, high_freq_oscillator_en_out, cpu_run_out}, 3'b110);
		check_val(clk_div_sel_out, 3'h0);
		wait_run(1'b0, n);
		check_lat(n, STAB + 1);
		access(1'b0, MEM_BUS_CTRL_ADDR, 8'h00, rd, n);
		check_val(rd, MEM_BUS_CTRL_RST);
		check_lat(n, 5);
		report_and_stop();
	end

	// Cuts a hang short well beyond the expected run length.
	initial
	begin
		#300us;
		miscompares++;
		report_and_stop();
	end
endmodule // bus_wait_and_standby_control_bench
